// >>> rtl/fpsc_host.sv
// Host controller for a parallel NOR flash: command sequences, status polling, id-exit recovery.
// Assumes a x16 flash wired word-wide; status, lock and protection bits are read from its data bus.
// Behaviour
// - Mode 01 holds status after success; host issues identification-exit.
// - After any failure host issues identification-exit to regain array reads.
// - Protect-voltage bit one on low supply; host then issues identification-exit.
// - Host resumes a suspended erase with one-cycle resume command.
// - Host locks user half with block lock bit zero, then identification-exit.
// - Host holds select and write strobes low with output enable high.
module fpsc_host
  import fpsc_pkg::*;
#(
  parameter int SUSP_WAIT = SUSP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_op,
  input  wire logic [20:0] cmd_addr,
  input  wire logic [15:0] cmd_data,
  output logic             cmd_ready,
  output logic             resp_valid,
  output logic [15:0]      resp_data,
  output logic [1:0]       resp_status,
  output logic [1:0]       status_mode,
  input  wire logic [15:0] dq_i,
  input  wire logic        ready_busy_i,
  output logic [20:0]      flash_addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             flash_reset_n
);
  typedef enum logic [2:0] {
    HS_RESET = 3'b000, HS_IDLE = 3'b001, HS_SEQ = 3'b010, HS_READ = 3'b011,
    HS_POLL1 = 3'b100, HS_POLL2 = 3'b101, HS_EXIT = 3'b110, HS_WAIT = 3'b111
  } fpsc_hs_e;

  fpsc_hs_e    state_reg;
  fpsc_op_e    op_reg;
  logic [20:0] addr_reg;
  logic [15:0] data_reg;
  logic [2:0]  idx_reg;
  logic        pend_reg;
  logic        start_reg;
  logic [15:0] cnt_reg;
  logic [15:0] first_reg;
  logic        fail_reg;
  logic [1:0]  fail_code_reg;
  logic        bus_done;
  logic [15:0] bus_rdata;

  // Sequence step table: {write address, write data} of step idx for an operation
  function automatic logic [36:0] seq_word(input fpsc_op_e op, input logic [2:0] idx,
                                           input logic [20:0] a, input logic [15:0] d);
    logic [7:0] third;
    third = CD_PROG;
    unique case (op)
      OP_SERASE, OP_LOCKDN: third = CD_ERASE;
      OP_SETCFG:            third = CD_SETCFG;
      OP_IDREAD:            third = CD_IDENT;
      OP_PPROG, OP_PLOCK:   third = CD_PPROG;
      default:              third = CD_PROG;
    endcase
    if (op == OP_SUSP) return {a, 8'h00, CD_SUSP};
    if (op == OP_RESUME) return {a, 8'h00, CD_RESUME};
    if (op == OP_IDEXIT) return {ADR_555, 8'h00, CD_IDEXIT};
    unique case (idx)
      3'd0: return {ADR_555, 8'h00, CD_AA};
      3'd1: return {ADR_AAA, 8'h00, CD_55};
      3'd2: return {ADR_555, 8'h00, third};
      3'd3: begin
        if (op == OP_PLOCK) return {ADR_PLK, d & ~16'(1 << BLOCK_LOCK_BIT)};
        if (op == OP_SETCFG) return {21'h000000, 14'h0000, d[1:0]};
        if (op == OP_PROG || op == OP_PPROG) return {a, d};
        return {ADR_555, 8'h00, CD_AA};
      end
      3'd4: return {ADR_AAA, 8'h00, CD_55};
      default: return {a, 8'h00, (op == OP_LOCKDN) ? CD_LOCKDN : CD_SERASE};
    endcase
  endfunction : seq_word

  // Number of write cycles of an operation's sequence
  function automatic logic [2:0] seq_len(input fpsc_op_e op);
    unique case (op)
      OP_SERASE, OP_LOCKDN:               return 3'd6;
      OP_PROG, OP_PPROG, OP_PLOCK, OP_SETCFG: return 3'd4;
      OP_IDREAD:                          return 3'd3;
      default:                            return 3'd1;
    endcase
  endfunction : seq_len

  // Decoding of the step table, of the polled status and of the operation's follow-up
  wire [36:0] step_word  = seq_word(op_reg, idx_reg, addr_reg, data_reg);
  wire        last_step  = (idx_reg == seq_len(op_reg) - 3'd1);
  wire        needs_poll = (op_reg == OP_PROG) || (op_reg == OP_SERASE) ||
                           (op_reg == OP_PPROG) || (op_reg == OP_PLOCK);
  wire        is_erase   = (op_reg == OP_SERASE);
  wire        toggling   = first_reg[TOGGLING_BIT] != bus_rdata[TOGGLING_BIT];
  wire        limit_err  = bus_rdata[LIMIT_ERROR_BIT];
  wire        vpp_err    = bus_rdata[PROTECT_VOLTAGE_BIT];
  wire        expect_bit = is_erase ? 1'b1 : data_reg[POLLING_BIT];
  wire        poll_ok    = (status_mode == 2'h1) ? bus_rdata[POLLING_BIT]
                                                 : (bus_rdata[POLLING_BIT] == expect_bit);
  // Bits 5 and 3 are status only while a status word shows; a mode 00 success returns array data
  wire        status_err = (limit_err || vpp_err) && !((status_mode == 2'h0) && poll_ok);
  wire        bus_write  = (state_reg != HS_READ) && (state_reg != HS_POLL1) && (state_reg != HS_POLL2);
  wire [20:0] bus_addr   = (state_reg == HS_EXIT) ? ADR_555 : (bus_write ? step_word[36:16] : addr_reg);
  wire [15:0] bus_wdata  = (state_reg == HS_EXIT) ? {8'h00, CD_IDEXIT} : step_word[15:0];
  wire        bus_state  = (state_reg != HS_RESET) && (state_reg != HS_IDLE) && (state_reg != HS_WAIT);

  fpsc_bus_cycle u_bus (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .start      (start_reg),
    .is_write   (bus_write),
    .addr       (bus_addr),
    .wdata      (bus_wdata),
    .dq_i       (dq_i),
    .flash_addr (flash_addr),
    .dq_o       (dq_o),
    .dq_oe      (dq_oe),
    .ce_n       (ce_n),
    .oe_n       (oe_n),
    .we_n       (we_n),
    .done       (bus_done),
    .rdata      (bus_rdata)
  );

  // Bus cycle launcher: one start per bus cycle, the step advances on the cycle's done pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_reg <= 1'b0;
      pend_reg  <= 1'b0;
    end else begin
      start_reg <= bus_state && !pend_reg && !start_reg;
      if (start_reg) pend_reg <= 1'b1;
      else if (bus_done) pend_reg <= 1'b0;
    end
  end

  // Main sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg     <= HS_RESET;
      op_reg        <= OP_READ;
      addr_reg      <= 21'h000000;
      data_reg      <= 16'h0000;
      idx_reg       <= 3'd0;
      cnt_reg       <= 16'(RST_CYC);
      first_reg     <= 16'h0000;
      fail_reg      <= 1'b0;
      fail_code_reg <= ST_OK;
      cmd_ready     <= 1'b0;
      resp_valid    <= 1'b0;
      resp_data     <= 16'h0000;
      resp_status   <= ST_OK;
      status_mode   <= CFG_RESET;
      flash_reset_n <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      if (cnt_reg != 16'h0000) cnt_reg <= cnt_reg - 16'h0001;
      unique case (state_reg)
        // Reset pulse: aborts any operation, clears every sector lock; status mode is kept
        HS_RESET: if (cnt_reg == 16'h0000) begin
          flash_reset_n <= 1'b1;
          cmd_ready     <= 1'b1;
          state_reg     <= HS_IDLE;
        end
        HS_IDLE: if (cmd_valid) begin
          cmd_ready <= 1'b0;
          op_reg    <= fpsc_op_e'(cmd_op);
          addr_reg  <= cmd_addr;
          data_reg  <= cmd_data;
          idx_reg   <= 3'd0;
          fail_reg  <= 1'b0;
          fail_code_reg <= ST_OK;
          if (fpsc_op_e'(cmd_op) == OP_RESET) begin
            flash_reset_n <= 1'b0;
            cnt_reg       <= 16'(RST_CYC);
            state_reg     <= HS_RESET;
          end else begin
            state_reg <= (fpsc_op_e'(cmd_op) == OP_READ) ? HS_READ : HS_SEQ;
          end
        end
        HS_SEQ: if (bus_done) begin
          idx_reg <= idx_reg + 3'd1;
          if (last_step) begin
            if (op_reg == OP_SETCFG) status_mode <= data_reg[1:0];
            if (op_reg == OP_IDREAD) state_reg <= HS_READ;
            else if (needs_poll) begin
              cnt_reg   <= 16'(GAP_CYC);
              state_reg <= HS_WAIT;
            end else if (op_reg == OP_SUSP) begin
              cnt_reg   <= 16'(SUSP_WAIT);
              state_reg <= HS_WAIT;
            end else begin
              resp_status <= ST_OK;
              resp_valid  <= 1'b1;
              cmd_ready   <= 1'b1;
              state_reg   <= HS_IDLE;
            end
          end
        end
        // Suspend latency or gap before the first status read
        HS_WAIT: if (cnt_reg == 16'h0000) begin
          if (needs_poll) state_reg <= HS_POLL1;
          else begin
            resp_status <= ST_OK;
            resp_valid  <= 1'b1;
            cmd_ready   <= 1'b1;
            state_reg   <= HS_IDLE;
          end
        end
        HS_READ: if (bus_done) begin
          resp_data <= bus_rdata;
          if (op_reg == OP_IDREAD) state_reg <= HS_EXIT;
          else begin
            resp_status <= ST_OK;
            resp_valid  <= 1'b1;
            cmd_ready   <= 1'b1;
            state_reg   <= HS_IDLE;
          end
        end
        HS_POLL1: if (bus_done) begin
          first_reg <= bus_rdata;
          state_reg <= HS_POLL2;
        end
        // Two reads back to back: a toggling bit that still moves means busy
        HS_POLL2: if (bus_done) begin
          resp_data <= bus_rdata;
          if (toggling && !status_err) state_reg <= HS_POLL1;
          else if (!toggling && poll_ok && !status_err) begin
            if (status_mode == 2'h1 || op_reg == OP_PLOCK) state_reg <= HS_EXIT;
            else begin
              resp_status <= ST_OK;
              resp_valid  <= 1'b1;
              cmd_ready   <= 1'b1;
              state_reg   <= HS_IDLE;
            end
          end else if (!toggling || status_err) begin
            fail_reg      <= 1'b1;
            fail_code_reg <= vpp_err ? ST_VPP : ST_LIMIT;
            state_reg     <= HS_EXIT;
          end
        end
        // Identification-exit restores array reads after status hold or id mode
        HS_EXIT: if (bus_done) begin
          resp_status <= fail_reg ? fail_code_reg : ST_OK;
          resp_valid  <= 1'b1;
          cmd_ready   <= 1'b1;
          state_reg   <= HS_IDLE;
        end
      endcase
    end
  end
endmodule : fpsc_host

// >>> common/fpsc_pkg.sv
// Constants, command codes and operation codes of the NOR flash program/status host controller.
// Assumes a word-wide (x16) flash with word addresses and a 250 MHz system clock.
package fpsc_pkg;
  localparam int CLK_NS = 4;
  // Bus timing, each figure in nanoseconds, then rounded up to clock cycles
  localparam int T_ACC_NS  = 70;
  localparam int T_WP_NS   = 40;
  localparam int T_SETUP_NS = 8;
  localparam int T_RST_NS  = 500;
  localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC   = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  // Longest suspend latency, in microseconds, and the default wait in cycles
  localparam int T_ESUSP_US = 15;
  localparam int T_PSUSP_US = 20;
  localparam int SUSP_CYC   = T_PSUSP_US * 1000 / CLK_NS;
  localparam int GAP_CYC    = 2;
  // Unlock addresses and command data
  localparam logic [20:0] ADR_555 = 21'h000555;
  localparam logic [20:0] ADR_AAA = 21'h000aaa;
  localparam logic [20:0] ADR_PLK = 21'h000080;
  localparam logic [7:0]  CD_AA    = 8'haa;
  localparam logic [7:0]  CD_55    = 8'h55;
  localparam logic [7:0]  CD_PROG  = 8'ha0;
  localparam logic [7:0]  CD_ERASE = 8'h80;
  localparam logic [7:0]  CD_SERASE = 8'h30;
  localparam logic [7:0]  CD_LOCKDN = 8'h60;
  localparam logic [7:0]  CD_SUSP  = 8'hb0;
  localparam logic [7:0]  CD_RESUME = 8'h30;
  localparam logic [7:0]  CD_SETCFG = 8'hd0;
  localparam logic [7:0]  CD_IDENT = 8'h90;
  localparam logic [7:0]  CD_IDEXIT = 8'hf0;
  localparam logic [7:0]  CD_PPROG = 8'hc0;
  // Status bit positions on the data bus
  localparam int POLLING_BIT   = 7;
  localparam int TOGGLING_BIT  = 6;
  localparam int LIMIT_ERROR_BIT = 5;
  localparam int PROTECT_VOLTAGE_BIT = 3;
  localparam int LOCK_FLAG_BIT = 0;
  localparam int BLOCK_LOCK_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  // Answer status codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_LIMIT = 2'h1;
  localparam logic [1:0] ST_VPP = 2'h2;
  typedef enum logic [3:0] {
    OP_READ   = 4'h0, OP_PROG  = 4'h1, OP_SERASE = 4'h2, OP_LOCKDN = 4'h3,
    OP_SUSP   = 4'h4, OP_RESUME = 4'h5, OP_SETCFG = 4'h6, OP_IDEXIT = 4'h7,
    OP_IDREAD = 4'h8, OP_PPROG = 4'h9, OP_PLOCK  = 4'ha, OP_RESET  = 4'hb
  } fpsc_op_e;
endpackage : fpsc_pkg

// >>> rtl/fpsc_bus_cycle.sv
// One asynchronous flash bus cycle (write pulse or read access) from a start pulse.
// Assumes the flash needs no clock; all pin timing is counted in sys_clk cycles.
module fpsc_bus_cycle
  import fpsc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] dq_i,
  output logic [20:0]      flash_addr,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             done,
  output logic [15:0]      rdata
);
  typedef enum logic [1:0] {
    BC_IDLE = 2'b00, BC_SETUP = 2'b01, BC_PULSE = 2'b10, BC_HOLD = 2'b11
  } fpsc_bc_e;

  fpsc_bc_e    state_reg;
  logic [7:0]  cnt_reg;
  logic        wr_reg;
  wire         cnt_zero = (cnt_reg == 8'h00);

  // Write: address and data settle with OE and WE high, then WE pulses low and the data is taken as it rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg  <= BC_IDLE;
      cnt_reg    <= 8'h00;
      wr_reg     <= 1'b0;
      flash_addr <= 21'h000000;
      dq_o       <= 16'h0000;
      dq_oe      <= 1'b0;
      ce_n       <= 1'b1;
      oe_n       <= 1'b1;
      we_n       <= 1'b1;
      done       <= 1'b0;
      rdata      <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
      unique case (state_reg)
        BC_IDLE: if (start) begin
          flash_addr <= addr;
          dq_o       <= wdata;
          dq_oe      <= is_write;
          wr_reg     <= is_write;
          ce_n       <= 1'b0;
          oe_n       <= 1'b1;
          cnt_reg    <= 8'(SETUP_CYC);
          state_reg  <= BC_SETUP;
        end
        BC_SETUP: if (cnt_zero) begin
          we_n      <= ~wr_reg;
          oe_n      <= wr_reg;
          cnt_reg   <= wr_reg ? 8'(WP_CYC) : 8'(ACC_CYC);
          state_reg <= BC_PULSE;
        end
        BC_PULSE: if (cnt_zero) begin
          we_n      <= 1'b1;
          ce_n      <= 1'b1;
          oe_n      <= 1'b1;
          rdata     <= dq_i;
          cnt_reg   <= 8'(SETUP_CYC);
          state_reg <= BC_HOLD;
        end
        BC_HOLD: if (cnt_zero) begin
          dq_oe     <= 1'b0;
          done      <= 1'b1;
          state_reg <= BC_IDLE;
        end
      endcase
    end
  end
endmodule : fpsc_bus_cycle

// >>> testbench/fpsc_host_properties.sv
// Concurrent checks on the pins and user port of the flash host controller.
// Assumes one clock domain, sys_clk, with the synchronous active-high rst.
module fpsc_host_properties
  import fpsc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       resp_valid,
  input wire logic [1:0] resp_status,
  input wire logic [1:0] status_mode,
  input wire logic       dq_oe,
  input wire logic       ce_n,
  input wire logic       oe_n,
  input wire logic       we_n,
  input wire logic       flash_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic [7:0] wlow_reg;
  // Length of the current write strobe, in cycles
  always_ff @(posedge sys_clk) begin
    if (rst || we_n) wlow_reg <= 8'h0;
    else wlow_reg <= wlow_reg + 8'h1;
  end
  chk_strobe_excl: assert property (!(!oe_n && !we_n))
    else $error("read and write strobes low together");
  chk_write_frame: assert property (!we_n |-> !ce_n && oe_n && dq_oe)
    else $error("write strobe without select or driven data");
  chk_read_float: assert property (!oe_n |-> we_n && !dq_oe)
    else $error("host drives data during a read");
  chk_reset_state: assert property ($fell(rst) |-> (!flash_reset_n && !cmd_ready && status_mode == 2'h0)[*8])
    else $error("state after reset release wrong");
  chk_flash_quiet: assert property (!flash_reset_n |-> ce_n && we_n && !cmd_ready)
    else $error("bus active while flash held in reset");
  chk_we_width: assert property ($rose(we_n) |-> wlow_reg >= WP_CYC)
    else $error("write strobe too short");
  chk_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready held after a request was taken");
  chk_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("answer strobe longer than one cycle");
  chk_mode_hold: assert property ($changed(status_mode) |-> resp_valid && !$past(cmd_ready))
    else $error("status mode changed outside a command");
  cov_limit: cover property (resp_valid && resp_status == ST_LIMIT);
  cov_vpp: cover property (resp_valid && resp_status == ST_VPP);
  cov_mode1: cover property (resp_valid && status_mode == 2'h1);
endmodule : fpsc_host_properties

bind fpsc_host fpsc_host_properties u_chk (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_status(resp_status), .status_mode(status_mode),
  .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .flash_reset_n(flash_reset_n));

// >>> testbench/fpsc_flash_model.sv
// Behavioural NOR flash facing the host controller: program, erase, lockdown, status output.
// Assumes host pins change only just after sys_clk edges; sector is address bits 20:15.
module fpsc_flash_model
  import fpsc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [20:0] flash_addr,
  input  wire logic [15:0] dq_o,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        flash_reset_n,
  input  int               vpp_mv,
  output logic [15:0]      dq_i,
  output logic             ready_busy_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [15:0] pr [4];
  logic [63:0] lk;
  logic [1:0]  cfg;
  logic [15:0] pd, pw, lastv, sd, rd;
  logic [20:0] pa;
  logic [7:0]  t3;
  int          n, bcnt, held;
  logic        pwe, poe, tog, er, stat, fl, lim, vpf, idm, plk;
  // Small word store: four sectors of sixteen words each
  function automatic int ix(input logic [20:0] a);
    return int'({a[16:15], a[3:0]});
  endfunction : ix
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    foreach (pr[i]) pr[i] = 16'hffff;
    {lk, n, bcnt, held, poe, tog, er, stat, fl, lim, vpf, idm, lastv, plk} = '0;
    cfg = 2'h0;
    pwe = 1'b1;
  end
  // Status word; mode 01 polls low while busy, mode 00 shows the inverse of the data
  assign sd = {8'h00, (stat && !fl) | (!cfg[0] && !er && !pd[7]), tog, lim, 1'b0, vpf, 3'h0};
  assign rd = idm ? ((flash_addr == ADR_PLK) ? {14'h0, ~plk, 1'b0}
                     : (flash_addr[20:2] == 19'h00023) ? pr[flash_addr[1:0]]
                     : {15'h0, lk[flash_addr[20:15]] & (flash_addr[14:0] == 15'h2)})
              : (bcnt > 0 || stat) ? sd : mem[ix(flash_addr)];
  // Released bus shows the inverse of the last word so a stale sample is caught
  assign dq_i = (!ce_n && !oe_n && flash_reset_n) ? rd : ~lastv;
  assign ready_busy_i = (bcnt > 0) ? 1'b0 : 1'b1;
  // Start an embedded cycle; a locked sector or low supply fails at once
  task automatic start(input logic [20:0] a, input logic [15:0] d, input logic e);
    er = e;
    pd = d;
    lim = lk[a[20:15]];
    vpf = !lim && vpp_mv < 900;
    fl = lim || vpf;
    stat = fl;
    if (fl) return;
    bcnt = e ? 60 : 40;
    if (!e) mem[ix(a)] = mem[ix(a)] & d;
    else for (int b = 0; b < 16; b++) mem[ix({a[20:4], b[3:0]})] = 16'hffff;
  endtask : start
  // Decode one write cycle
  task automatic cmd(input logic [20:0] a, input logic [15:0] d);
    if (n == 0 && d[7:0] == CD_SUSP) begin
      held = bcnt;
      bcnt = 0;
      return;
    end
    if (bcnt > 0) return;
    if (n == 0 && d[7:0] == CD_RESUME) begin
      bcnt = held;
      held = 0;
      return;
    end
    n++;
    if (n == 3) t3 = d[7:0];
    if (d[7:0] == CD_IDEXIT) begin
      {n, idm, stat, fl, lim, vpf} = '0;
    end else if (n == 3 && t3 == CD_IDENT) begin
      idm = 1'b1;
      n = 0;
    end else if (n == 4 && t3 != CD_ERASE) begin
      if (t3 == CD_SETCFG) cfg = d[1:0];
      if (t3 == CD_PROG) start(a, d, 1'b0);
      if (t3 == CD_PPROG && a == ADR_PLK) plk = plk | !d[BLOCK_LOCK_BIT];
      else if (t3 == CD_PPROG && !plk) pr[a[1:0]] = pr[a[1:0]] & d;
      if (t3 == CD_PPROG) begin
        {er, lim, vpf, fl, stat} = '0;
        pd = d;
        bcnt = 40;
      end
      n = 0;
    end else if (n == 6) begin
      if (d[7:0] == CD_LOCKDN) lk[a[20:15]] = 1'b1;
      if (d[7:0] == CD_SERASE) start(a, d, 1'b1);
      n = 0;
    end
  endtask : cmd
  // Data is taken at the rising write strobe, from values held while it was low
  // Sampled mid-cycle so the host's flops never race the model's blocking updates
  always @(negedge sys_clk) begin
    if (!flash_reset_n) begin
      {lk, bcnt, held, stat, idm, n} = '0;
    end else begin
      if (bcnt == 1) stat = cfg[0];
      if (bcnt > 0) bcnt--;
      if (poe && !oe_n && !ce_n && bcnt > 0) tog = ~tog;
      if (!pwe && we_n) cmd(pa, pw);
    end
    if (!ce_n && !oe_n) lastv = rd;
    pwe = we_n;
    poe = oe_n;
    pa = flash_addr;
    pw = dq_o;
  end
endmodule : fpsc_flash_model

// >>> testbench/tb.sv
// Self-checking bench: command sequences on the user port against the flash model.
// Assumes a 250 MHz clock and the model driving data-in and the completion line.
module tb
  import fpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst, cmd_valid, cmd_ready, resp_valid, dq_oe, ce_n, oe_n, we_n, flash_reset_n, rdy;
  logic [3:0]  cmd_op;
  logic [20:0] cmd_addr, flash_addr;
  logic [15:0] cmd_data, resp_data, dq_i, dq_o;
  logic [1:0]  resp_status, status_mode;
  int          errors, total_checks, vpp_mv, last_wait;
  fpsc_host #(.SUSP_WAIT(20)) i_dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_status(resp_status), .status_mode(status_mode), .dq_i(dq_i),
    .ready_busy_i(rdy), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .flash_reset_n(flash_reset_n));
  fpsc_flash_model i_flash (.sys_clk(sys_clk), .flash_addr(flash_addr), .dq_o(dq_o), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .flash_reset_n(flash_reset_n), .vpp_mv(vpp_mv), .dq_i(dq_i), .ready_busy_i(rdy));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Request held until taken, then the answer strobe awaited under a bound
  task automatic do_cmd(input fpsc_op_e op, input logic [20:0] a, input logic [15:0] d);
    int k;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (cmd_ready !== 1'b1 && k < 500);
    cmd_valid <= 1'b0;
    k = 0;
    // A flash reset answers only by raising ready again
    do begin @(posedge sys_clk); k++; end
    while (resp_valid !== 1'b1 && (op != OP_RESET || cmd_ready !== 1'b1) && k < 20000);
    last_wait = k;
    if (k >= 20000) errors++;
  endtask : do_cmd
  task automatic op_chk(input fpsc_op_e op, input logic [20:0] a, input logic [15:0] d, input logic [1:0] st);
    do_cmd(op, a, d);
    chk("status", {14'h0, resp_status}, {14'h0, st});
  endtask : op_chk
  task automatic rd_chk(input fpsc_op_e op, input logic [20:0] a, input logic [15:0] exp);
    do_cmd(op, a, 16'h0);
    chk("rdata", resp_data, exp);
  endtask : rd_chk
  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end
  // Test sequence
  initial begin
    {errors, total_checks} = '0;
    vpp_mv = 1200;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_addr = 21'h0;
    cmd_data = 16'h0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("mode", {14'h0, status_mode}, 16'h0);
    rd_chk(OP_READ, 21'h10, 16'hffff);
    op_chk(OP_PROG, 21'h10, 16'h12b4, ST_OK);
    rd_chk(OP_READ, 21'h10, 16'h12b4);
    op_chk(OP_PROG, 21'h10, 16'hff0f, ST_OK);
    rd_chk(OP_READ, 21'h10, 16'h1204);
    op_chk(OP_SUSP, 21'h0, 16'h0, ST_OK);
    chk("susp_wait", 16'(last_wait >= 20 + WP_CYC + 2 * SETUP_CYC), 16'h0001);
    op_chk(OP_RESUME, 21'h0, 16'h0, ST_OK);
    $display("test program done");
    op_chk(OP_SETCFG, 21'h0, 16'h0001, ST_OK);
    chk("mode", {14'h0, status_mode}, 16'h1);
    op_chk(OP_PROG, 21'h11, 16'h0f0f, ST_OK);
    rd_chk(OP_READ, 21'h11, 16'h0f0f);
    $display("test mode done");
    op_chk(OP_LOCKDN, 21'h8000, 16'h0, ST_OK);
    rd_chk(OP_IDREAD, 21'h8002, 16'h0001);
    rd_chk(OP_IDREAD, 21'h0002, 16'h0000);
    op_chk(OP_PROG, 21'h8003, 16'h0000, ST_LIMIT);
    op_chk(OP_SERASE, 21'h8000, 16'h0, ST_LIMIT);
    rd_chk(OP_READ, 21'h8003, 16'hffff);
    do_cmd(OP_RESET, 21'h0, 16'h0);
    chk("mode", {14'h0, status_mode}, 16'h1);
    rd_chk(OP_IDREAD, 21'h8002, 16'h0000);
    op_chk(OP_IDEXIT, 21'h0, 16'h0, ST_OK);
    op_chk(OP_PPROG, 21'h8c, 16'h1234, ST_OK);
    rd_chk(OP_IDREAD, 21'h8c, 16'h1234);
    op_chk(OP_PLOCK, ADR_PLK, 16'hffff, ST_OK);
    rd_chk(OP_IDREAD, ADR_PLK, 16'h0000);
    op_chk(OP_SETCFG, 21'h0, 16'h0000, ST_OK);
    $display("test lockdown done");
    vpp_mv <= 300;
    op_chk(OP_PROG, 21'h12, 16'h0000, ST_VPP);
    rd_chk(OP_READ, 21'h12, 16'hffff);
    vpp_mv <= 900;
    op_chk(OP_PROG, 21'h12, 16'h5555, ST_OK);
    rd_chk(OP_READ, 21'h12, 16'h5555);
    $display("test supply done");
    op_chk(OP_SERASE, 21'h0, 16'h0, ST_OK);
    rd_chk(OP_READ, 21'h10, 16'hffff);
    $display("test erase done");
    wrap_up();
  end
endmodule : tb
